// ---- design/homing_pkg.sv ----
// package: object dictionary map, method codes and sequencer states for the homing block
package homing_pkg;
   localparam logic [15:0] IDX_HOME_OFFSET    = 16'h607c;
   localparam logic [15:0] IDX_HOMING_METHOD  = 16'h6098;
   localparam logic [15:0] IDX_HOMING_SPEEDS  = 16'h6099;
   localparam logic [15:0] IDX_HOMING_ACCEL   = 16'h609a;
   localparam logic [15:0] IDX_POS_DEMAND     = 16'h6062;
   localparam logic [15:0] IDX_POS_ACTUAL     = 16'h6063;
   localparam logic [15:0] IDX_CONTROL_EFFORT = 16'h60fa;
   localparam logic [15:0] IDX_EFFORT_LIMIT   = 16'h60fb;
   localparam logic [7:0]  SUB_COUNT          = 8'h00;
   localparam logic [7:0]  SUB_SWITCH_SPEED   = 8'h01;
   localparam logic [7:0]  SUB_ZERO_SPEED     = 8'h02;
   localparam logic [31:0] SPEED_ENTRY_COUNT  = 32'h0000_0002;
   localparam logic [31:0] RESET_WORD         = 32'h0000_0000;
   localparam logic [31:0] RESET_EFFORT_LIMIT = 32'h7fff_ffff;
   localparam logic [7:0]  METHOD_NONE        = 8'h00;
   localparam logic [7:0]  METHOD_LAST_INDEX  = 8'h0e;
   localparam logic [7:0]  METHOD_FIRST_SW    = 8'h11;
   localparam logic [7:0]  METHOD_LAST_SW     = 8'h1e;
   localparam logic [7:0]  METHOD_INDEX_NEG   = 8'h21;
   localparam logic [7:0]  METHOD_INDEX_POS   = 8'h22;
   localparam logic [7:0]  METHOD_CURRENT     = 8'h23;
   localparam logic [7:0]  METHOD_MIRROR_STEP = 8'h10;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SEEK   = 3'b001,
      ST_BACK   = 3'b010,
      ST_INDEX  = 3'b011,
      ST_STOP   = 3'b100,
      ST_DONE   = 3'b101,
      ST_FAULT  = 3'b110
   } homing_state_type;

   // home signal that ends the switch search
   typedef enum logic [1:0] {
      SRC_NEG_LIMIT = 2'b00,
      SRC_POS_LIMIT = 2'b01,
      SRC_HOME_SW   = 2'b10,
      SRC_NONE      = 2'b11
   } home_source_type;
endpackage : homing_pkg

// ---- design/motion_if.sv ----
// interface: commands between the sequencer and its ramp and limiter units
`timescale 1ns/1ps
`default_nettype none
interface motion_if;
   logic        move_en;
   logic        dir_pos;
   logic [31:0] target_speed;
   logic [31:0] accel;
   logic [31:0] speed;
   logic        at_rest;
   logic [31:0] raw_effort;
   logic [31:0] limit;
   logic [31:0] effort;
   modport seq   (output move_en, dir_pos, target_speed, accel, raw_effort, limit,
                  input speed, at_rest, effort);
   modport ramp  (input move_en, target_speed, accel, output speed, at_rest);
   modport clamp (input raw_effort, limit, output effort);
endinterface : motion_if
`default_nettype wire

// ---- design/speed_ramp.sv ----
// module: trapezoidal speed ramp using one acceleration for both directions of change
`timescale 1ns/1ps
`default_nettype none
module speed_ramp
   import homing_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic srst,
   motion_if.ramp    m
);
   logic [31:0] speed_q;
   logic [31:0] speed_d;
   logic [31:0] goal;
   logic [32:0] up;

   always_comb begin
      goal = m.move_en ? m.target_speed : RESET_WORD;
      up   = {1'b0, speed_q} + {1'b0, m.accel};
      speed_d = speed_q;
      if (speed_q < goal) begin
         speed_d = (up[32] || up[31:0] > goal) ? goal : up[31:0];
      end else if (speed_q > goal) begin
         speed_d = (speed_q - goal < m.accel) ? goal : speed_q - m.accel;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) speed_q <= RESET_WORD;
      else      speed_q <= speed_d;
   end

   assign m.speed   = speed_q;
   assign m.at_rest = (speed_q == RESET_WORD);
endmodule : speed_ramp
`default_nettype wire

// ---- design/effort_clamp.sv ----
// module: absolute limiter on the signed control effort
`timescale 1ns/1ps
`default_nettype none
module effort_clamp (
   motion_if.clamp m
);
   logic signed [31:0] raw;
   logic signed [31:0] lim;
   always_comb begin
      raw = m.raw_effort;
      lim = {1'b0, m.limit[30:0]};
      if (raw > lim)       m.effort = lim;
      else if (raw < -lim) m.effort = -lim;
      else                 m.effort = raw;
   end
endmodule : effort_clamp
`default_nettype wire

// ---- design/drive_homing_sequencer.sv ----
// module: homing sequencer with dictionary access and position loop values
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - speed array count reads 2; entry 1 is switch search speed, reset zero
// - entry 2 is the zero/index search speed, reset zero
// - one homing acceleration drives every ramp up and down
// - home sources: negative limit, positive limit, home switch, index; a hard stop faults while seeking, backing or indexing, not in the final stop
// - rightward motion raises the encoder count
// - method 1 starts leftward when negative limit is inactive
// - method 1 homes at first index right of negative limit release
// - method 2 starts rightward when positive limit is inactive
// - method 2 homes at first index left of positive limit release
// - methods 3,4 start by home switch state, home at nearby index
// - methods 5,6 start by home switch state, home at nearby index
// - reversal may happen anywhere after the home switch changes
// - methods 7-10 start rightward, 11-14 leftward, unless switch active
// - with switch active at start, direction follows the sought edge
// - moving away from home switch reverses at the limit switch
// - methods 17-30 mirror 1-14 but home at the switch edge itself
// - method 33 searches negative, 34 positive, home at first index
// - method 35 takes present position as home without motion
// - zero position differs from home by the home offset
// - position demand value is read only, 32 bits, reset zero
// - position actual value is in encoder increments
// - control effort is clamped to an absolute limit
// - on completion zero equals home plus offset for later moves
// - method zero performs no homing motion
module drive_homing_sequencer
   import homing_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        od_wr,
   input  wire logic        od_rd,
   input  wire logic [15:0] od_index,
   input  wire logic [7:0]  od_subindex,
   input  wire logic [31:0] od_wdata,
   output logic [31:0]      od_rdata,
   output logic             od_ack,
   output logic             od_err,
   input  wire logic        homing_start,
   input  wire logic        neg_limit,
   input  wire logic        pos_limit,
   input  wire logic        home_switch,
   input  wire logic        index_pulse,
   input  wire logic        hard_stop,
   input  wire logic [31:0] encoder_count,
   input  wire logic [31:0] loop_effort,
   output logic             motion_active,
   output logic             motion_dir_pos,
   output logic [31:0]      motion_speed,
   output logic             homing_done,
   output logic             homing_error,
   output logic [31:0]      position_demand,
   output logic [31:0]      control_effort
);
   motion_if mif ();
   speed_ramp u_ramp (.ref_clk(ref_clk), .srst(srst), .m(mif.ramp));
   effort_clamp u_clamp (.m(mif.clamp));

   // ================= dictionary storage =================
   logic [31:0] switch_speed_q, switch_speed_d;
   logic [31:0] zero_speed_q, zero_speed_d;
   logic [31:0] accel_q, accel_d;
   logic [31:0] offset_q, offset_d;
   logic [7:0]  method_q, method_d;
   logic [31:0] limit_q, limit_d;
   logic [31:0] rdata_q, rdata_d;
   logic        ack_q, ack_d, err_q, err_d;

   // ================= sequencer state =================
   homing_state_type state_q, state_d;
   logic             dir_q, dir_d;
   logic             fast_q, fast_d;
   logic             sw_prev_q, sw_prev_d;
   logic [31:0]      home_q, home_d;
   logic [31:0]      demand_q, demand_d;
   logic [31:0]      effort_q, effort_d;
   logic             done_q, done_d;
   logic             fail_q, fail_d;
   logic             active_q, active_d;
   logic [31:0]      mspeed_q, mspeed_d;

   // ================= method decode =================
   logic [7:0]      base;
   logic            use_index;
   logic            defined;
   home_source_type src;
   logic            src_level;
   logic            sw_now;
   logic            start_pos;
   logic            sought_edge_high;

   always_comb begin
      defined   = 1'b1;
      use_index = 1'b1;
      base      = method_q;
      if (method_q >= METHOD_FIRST_SW && method_q <= METHOD_LAST_SW) begin
         base      = method_q - METHOD_MIRROR_STEP;
         use_index = 1'b0;
      end else if (method_q == METHOD_NONE || method_q > METHOD_CURRENT ||
                   (method_q > METHOD_LAST_INDEX && method_q < METHOD_INDEX_NEG)) begin
         defined = 1'b0;
      end
      src              = SRC_HOME_SW;
      start_pos        = 1'b1;
      sought_edge_high = 1'b0;
      unique case (base)
         8'h01: begin
            src       = SRC_NEG_LIMIT;
            start_pos = 1'b0;
         end
         8'h02: src = SRC_POS_LIMIT;
         8'h03, 8'h04: start_pos = ~home_switch;
         8'h05, 8'h06: start_pos = home_switch;
         8'h07, 8'h08, 8'h09, 8'h0a: begin
            sought_edge_high = base[0];
            start_pos = home_switch ? ~base[0] : 1'b1;
         end
         8'h0b, 8'h0c, 8'h0d, 8'h0e: begin
            sought_edge_high = base[0];
            start_pos = home_switch ? base[0] : 1'b0;
         end
         8'h21: begin
            src       = SRC_NONE;
            start_pos = 1'b0;
         end
         8'h22: src = SRC_NONE;
         default: src = SRC_NONE;
      endcase
      unique case (src)
         SRC_NEG_LIMIT: src_level = neg_limit;
         SRC_POS_LIMIT: src_level = pos_limit;
         SRC_HOME_SW:   src_level = home_switch;
         SRC_NONE:      src_level = 1'b0;
      endcase
      sw_now = src_level;
   end

   // ================= dictionary access =================
   always_comb begin
      switch_speed_d = switch_speed_q;
      zero_speed_d   = zero_speed_q;
      accel_d        = accel_q;
      offset_d       = offset_q;
      method_d       = method_q;
      limit_d        = limit_q;
      rdata_d        = RESET_WORD;
      ack_d          = od_wr | od_rd;
      err_d          = 1'b0;
      if (od_wr) begin
         unique case (od_index)
            IDX_HOMING_SPEEDS:
               if (od_subindex == SUB_SWITCH_SPEED) switch_speed_d = od_wdata;
               else if (od_subindex == SUB_ZERO_SPEED) zero_speed_d = od_wdata;
               else err_d = 1'b1;
            IDX_HOMING_ACCEL:  accel_d  = od_wdata;
            IDX_HOME_OFFSET:   offset_d = od_wdata;
            IDX_HOMING_METHOD: method_d = od_wdata[7:0];
            IDX_EFFORT_LIMIT:  limit_d  = od_wdata;
            default: err_d = 1'b1;
         endcase
      end else if (od_rd) begin
         unique case (od_index)
            IDX_HOMING_SPEEDS:
               if (od_subindex == SUB_COUNT)             rdata_d = SPEED_ENTRY_COUNT;
               else if (od_subindex == SUB_SWITCH_SPEED) rdata_d = switch_speed_q;
               else if (od_subindex == SUB_ZERO_SPEED)   rdata_d = zero_speed_q;
               else err_d = 1'b1;
            IDX_HOMING_ACCEL:   rdata_d = accel_q;
            IDX_HOME_OFFSET:    rdata_d = offset_q;
            IDX_HOMING_METHOD:  rdata_d = {24'h00_0000, method_q};
            IDX_EFFORT_LIMIT:   rdata_d = limit_q;
            IDX_POS_DEMAND:     rdata_d = demand_q;
            IDX_POS_ACTUAL:     rdata_d = encoder_count;
            IDX_CONTROL_EFFORT: rdata_d = effort_q;
            default: err_d = 1'b1;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         switch_speed_q <= RESET_WORD;
         zero_speed_q   <= RESET_WORD;
         accel_q        <= RESET_WORD;
         offset_q       <= RESET_WORD;
         method_q       <= METHOD_NONE;
         limit_q        <= RESET_EFFORT_LIMIT;
         rdata_q        <= RESET_WORD;
         ack_q          <= 1'b0;
         err_q          <= 1'b0;
      end else begin
         switch_speed_q <= switch_speed_d;
         zero_speed_q   <= zero_speed_d;
         accel_q        <= accel_d;
         offset_q       <= offset_d;
         method_q       <= method_d;
         limit_q        <= limit_d;
         rdata_q        <= rdata_d;
         ack_q          <= ack_d;
         err_q          <= err_d;
      end
   end

   // ================= homing sequence =================
   logic away_limit;
   assign away_limit = dir_q ? pos_limit : neg_limit;

   always_comb begin
      state_d   = state_q;
      dir_d     = dir_q;
      fast_d    = fast_q;
      sw_prev_d = sw_now;
      home_d    = home_q;
      done_d    = done_q;
      fail_d    = fail_q;
      unique case (state_q)
         ST_IDLE, ST_DONE, ST_FAULT: begin
            if (homing_start) begin
               done_d = 1'b0;
               fail_d = 1'b0;
               dir_d  = start_pos;
               fast_d = 1'b1;
               if (!defined) begin
                  state_d = ST_IDLE;
               end else if (method_q == METHOD_CURRENT) begin
                  home_d  = encoder_count;
                  state_d = ST_STOP;
               end else if (src == SRC_NONE) begin
                  fast_d  = 1'b0;
                  state_d = ST_INDEX;
               end else begin
                  state_d = ST_SEEK;
               end
            end
         end
         ST_SEEK: begin
            if (hard_stop) begin
               state_d = ST_FAULT;
            end else if (src != SRC_HOME_SW && sw_now) begin
               dir_d   = ~dir_q;
               fast_d  = 1'b0;
               state_d = ST_BACK;
            end else if (src == SRC_HOME_SW && sw_now != sw_prev_q) begin
               if (sw_now == sought_edge_high || base < 8'h07) begin
                  dir_d   = ~dir_q;
                  fast_d  = 1'b0;
                  state_d = ST_BACK;
               end
            end else if (src == SRC_HOME_SW && away_limit) begin
               dir_d = ~dir_q;
            end
         end
         ST_BACK: begin
            // creep back until the home signal changes level
            if (hard_stop) begin
               state_d = ST_FAULT;
            end else if (sw_now != sw_prev_q) begin
               if (use_index) begin
                  state_d = ST_INDEX;
               end else begin
                  home_d  = encoder_count;
                  state_d = ST_STOP;
               end
            end
         end
         ST_INDEX: begin
            if (hard_stop || away_limit) begin
               state_d = ST_FAULT;
            end else if (index_pulse) begin
               home_d  = encoder_count;
               state_d = ST_STOP;
            end
         end
         ST_STOP: begin
            if (mif.at_rest) begin
               done_d  = 1'b1;
               state_d = ST_DONE;
            end
         end
         default: state_d = ST_FAULT;
      endcase
      if (state_d == ST_FAULT && state_q != ST_FAULT) fail_d = 1'b1;
   end

   always_comb begin
      mif.move_en      = (state_q == ST_SEEK) || (state_q == ST_BACK) ||
                         (state_q == ST_INDEX);
      mif.dir_pos      = dir_q;
      mif.target_speed = fast_q ? switch_speed_q : zero_speed_q;
      mif.accel        = accel_q;
      mif.raw_effort   = loop_effort;
      mif.limit        = limit_q;
      active_d         = !mif.at_rest || mif.move_en;
      mspeed_d         = mif.speed;
      effort_d         = mif.effort;
      demand_d         = demand_q;
      if (state_q == ST_STOP && state_d == ST_DONE) begin
         demand_d = home_q + offset_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q   <= ST_IDLE;
         dir_q     <= 1'b0;
         fast_q    <= 1'b0;
         sw_prev_q <= 1'b0;
         home_q    <= RESET_WORD;
         demand_q  <= RESET_WORD;
         effort_q  <= RESET_WORD;
         done_q    <= 1'b0;
         fail_q    <= 1'b0;
         active_q  <= 1'b0;
         mspeed_q  <= RESET_WORD;
      end else begin
         state_q   <= state_d;
         dir_q     <= dir_d;
         fast_q    <= fast_d;
         sw_prev_q <= sw_prev_d;
         home_q    <= home_d;
         demand_q  <= demand_d;
         effort_q  <= effort_d;
         done_q    <= done_d;
         fail_q    <= fail_d;
         active_q  <= active_d;
         mspeed_q  <= mspeed_d;
      end
   end

   assign od_rdata        = rdata_q;
   assign od_ack          = ack_q;
   assign od_err          = err_q;
   assign motion_active   = active_q;
   assign motion_dir_pos  = dir_q;
   assign motion_speed    = mspeed_q;
   assign homing_done     = done_q;
   assign homing_error    = fail_q;
   assign position_demand = demand_q;
   assign control_effort  = effort_q;
endmodule : drive_homing_sequencer
`default_nettype wire

// ---- test/drive_homing_sequencer_props.sv ----
// checker: dictionary handshake and motion relations of the homing sequencer
`timescale 1ns/1ps
`default_nettype none
module drive_homing_sequencer_props (
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        od_wr,
   input wire logic        od_rd,
   input wire logic [15:0] od_index,
   input wire logic [7:0]  od_subindex,
   input wire logic [31:0] od_rdata,
   input wire logic        od_ack,
   input wire logic        od_err,
   input wire logic        motion_active,
   input wire logic [31:0] motion_speed,
   input wire logic        homing_done
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // ==========================================================
   // dictionary access
   a_ack_after_strobe: assert property ((od_wr || od_rd) |=> od_ack)
      else $error("no answer one cycle after a dictionary strobe");
   a_ack_has_cause: assert property (od_ack |-> $past(od_wr || od_rd))
      else $error("answer without a strobe one cycle before");
   a_count_reads_two: assert property ((od_rd && !od_wr && od_index == 16'h6099 &&
      od_subindex == 8'h00) |=> (od_rdata == 32'h0000_0002 && !od_err))
      else $error("speed entry count did not read two");
   a_count_write_err: assert property ((od_wr && od_index == 16'h6099 &&
      od_subindex == 8'h00) |=> (od_ack && od_err))
      else $error("write to speed entry count not refused");
   a_demand_read_only: assert property ((od_wr && od_index == 16'h6062) |=> od_err)
      else $error("write to position demand not refused");
   a_err_with_ack: assert property (od_err |-> (od_ack && od_rdata == 32'h0))
      else $error("refusal without answer or with data");
   // ==========================================================
   // motion
   a_rest_zero_speed: assert property (!motion_active |-> motion_speed == 32'h0)
      else $error("speed command while not moving");
   a_done_at_rest: assert property (homing_done |-> !motion_active)
      else $error("homing done while axis still moving");
endmodule : drive_homing_sequencer_props
bind drive_homing_sequencer drive_homing_sequencer_props u_props (
   .ref_clk(ref_clk), .srst(srst), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
   .od_subindex(od_subindex), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
   .motion_active(motion_active), .motion_speed(motion_speed), .homing_done(homing_done));
`default_nettype wire

// ---- test/axis_model.sv ----
// model: axis with limit switches, home switch, index track and encoder
`timescale 1ns/1ps
`default_nettype none
module axis_model (
   input  wire logic        ref_clk,
   input  wire logic        load,
   input  wire logic [31:0] load_pos,
   input  wire logic        motion_active,
   input  wire logic        motion_dir_pos,
   input  wire logic [31:0] motion_speed,
   output logic [31:0]      encoder_count,
   output logic             neg_limit,
   output logic             pos_limit,
   output logic             home_switch,
   output logic             index_pulse
);
   logic [31:0] pos_q;
   // one count per cycle while a speed is commanded
   always_ff @(posedge ref_clk) begin
      if (load) begin
         pos_q <= load_pos;
      end else if (motion_active && motion_speed != 32'h0) begin
         pos_q <= motion_dir_pos ? pos_q + 32'h1 : pos_q - 32'h1;
      end
   end
   assign encoder_count = pos_q;
   assign neg_limit     = $signed(pos_q) <= 200;
   assign pos_limit     = $signed(pos_q) >= 1800;
   assign home_switch   = pos_q >= 32'd600 && pos_q <= 32'd700;
   assign index_pulse   = pos_q[5:0] == 6'h00;
endmodule : axis_model
`default_nettype wire

// ---- test/drive_homing_sequencer_tb_top.sv ----
// testbench: dictionary access, refused methods and homing runs
`timescale 1ns/1ps
`default_nettype none
module drive_homing_sequencer_tb_top;
   import homing_pkg::*;
   logic ref_clk = 1'b0;
   logic srst, od_wr, od_rd, od_ack, od_err, homing_start, load, hard_stop;
   logic neg_limit, pos_limit, home_switch, index_pulse;
   logic motion_active, motion_dir_pos, homing_done, homing_error;
   logic [15:0] od_index;
   logic [7:0]  od_subindex;
   logic [31:0] od_wdata, od_rdata, encoder_count, loop_effort, motion_speed;
   logic [31:0] position_demand, control_effort, load_pos;
   int          err_total = 0;
   int          num_checks = 0;
   always #5 ref_clk = ~ref_clk;
   drive_homing_sequencer u_dut (.ref_clk(ref_clk), .srst(srst), .od_wr(od_wr),
      .od_rd(od_rd), .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata),
      .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err), .homing_start(homing_start),
      .neg_limit(neg_limit), .pos_limit(pos_limit), .home_switch(home_switch),
      .index_pulse(index_pulse), .hard_stop(hard_stop), .encoder_count(encoder_count),
      .loop_effort(loop_effort), .motion_active(motion_active),
      .motion_dir_pos(motion_dir_pos), .motion_speed(motion_speed),
      .homing_done(homing_done), .homing_error(homing_error),
      .position_demand(position_demand), .control_effort(control_effort));
   axis_model u_axis (.ref_clk(ref_clk), .load(load), .load_pos(load_pos),
      .motion_active(motion_active), .motion_dir_pos(motion_dir_pos),
      .motion_speed(motion_speed), .encoder_count(encoder_count), .neg_limit(neg_limit),
      .pos_limit(pos_limit), .home_switch(home_switch), .index_pulse(index_pulse));
   // ==========================================================
   // tasks
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic od_check(input string what, input logic wr, input logic [15:0] idx,
                           input logic [7:0] sub, input logic [31:0] val, input logic ex_err);
      @(posedge ref_clk);
      #1;
      od_wr = wr;
      od_rd = !wr;
      od_index = idx;
      od_subindex = sub;
      od_wdata = val;
      @(posedge ref_clk);
      #1;
      od_wr = 1'b0;
      od_rd = 1'b0;
      chk({what, " ack"}, 32'h1, {31'h0, od_ack});
      chk({what, " err"}, {31'h0, ex_err}, {31'h0, od_err});
      if (!wr && !ex_err) chk(what, val, od_rdata);
   endtask : od_check
   task automatic run_home(input logic [7:0] meth, input logic [31:0] home,
                           input logic dir, input logic good);
      logic moved;
      moved = 1'b0;
      od_check("method", 1'b1, IDX_HOMING_METHOD, 8'h00, {24'h0, meth}, 1'b0);
      load = 1'b1;
      load_pos = 32'd1000;
      @(posedge ref_clk);
      #1;
      load = 1'b0;
      od_check("actual", 1'b0, IDX_POS_ACTUAL, 8'h00, 32'd1000, 1'b0);
      homing_start = 1'b1;
      @(posedge ref_clk);
      #1;
      homing_start = 1'b0;
      for (int i = 0; i < (good ? 4000 : 40) && homing_done !== 1'b1; i++) begin
         if (motion_active === 1'b1 && !moved) begin
            chk("start direction", {31'h0, dir}, {31'h0, motion_dir_pos});
            moved = 1'b1;
         end
         @(posedge ref_clk);
         #1;
      end
      chk("moved", {31'h0, good && meth != 8'd35}, {31'h0, moved});
      chk("done", {31'h0, good}, {31'h0, homing_done});
      chk("error", 32'h0, {31'h0, homing_error});
      if (good) chk("demand", home + 32'd5, position_demand);
   endtask : run_home
   // ==========================================================
   // sequence
   initial begin
      srst = 1'b1;
      od_wr = 1'b0;
      od_rd = 1'b0;
      od_index = 16'h0;
      od_subindex = 8'h0;
      od_wdata = 32'h0;
      homing_start = 1'b0;
      hard_stop = 1'b0;
      loop_effort = 32'h0;
      load = 1'b1;
      load_pos = 32'd1000;
      repeat (4) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      load = 1'b0;
      od_check("count", 1'b0, IDX_HOMING_SPEEDS, SUB_COUNT, SPEED_ENTRY_COUNT, 1'b0);
      od_check("count wr", 1'b1, IDX_HOMING_SPEEDS, SUB_COUNT, 32'h0, 1'b1);
      od_check("speed1", 1'b0, IDX_HOMING_SPEEDS, SUB_SWITCH_SPEED, RESET_WORD, 1'b0);
      od_check("speed2", 1'b0, IDX_HOMING_SPEEDS, SUB_ZERO_SPEED, RESET_WORD, 1'b0);
      od_check("accel", 1'b0, IDX_HOMING_ACCEL, 8'h00, RESET_WORD, 1'b0);
      od_check("demand", 1'b0, IDX_POS_DEMAND, 8'h00, RESET_WORD, 1'b0);
      od_check("demand wr", 1'b1, IDX_POS_DEMAND, 8'h00, 32'h1, 1'b1);
      od_check("unmapped", 1'b0, 16'h1234, 8'h00, 32'h0, 1'b1);
      od_check("speed1 wr", 1'b1, IDX_HOMING_SPEEDS, SUB_SWITCH_SPEED, 32'h4, 1'b0);
      od_check("speed2 wr", 1'b1, IDX_HOMING_SPEEDS, SUB_ZERO_SPEED, 32'h2, 1'b0);
      od_check("accel wr", 1'b1, IDX_HOMING_ACCEL, 8'h00, 32'h1, 1'b0);
      od_check("speed1", 1'b0, IDX_HOMING_SPEEDS, SUB_SWITCH_SPEED, 32'h4, 1'b0);
      od_check("speed2", 1'b0, IDX_HOMING_SPEEDS, SUB_ZERO_SPEED, 32'h2, 1'b0);
      od_check("accel", 1'b0, IDX_HOMING_ACCEL, 8'h00, 32'h1, 1'b0);
      od_check("offset wr", 1'b1, IDX_HOME_OFFSET, 8'h00, 32'd5, 1'b0);
      run_home(8'd0, 32'd0, 1'b0, 1'b0);
      run_home(8'd15, 32'd0, 1'b0, 1'b0);
      run_home(8'd16, 32'd0, 1'b0, 1'b0);
      run_home(8'd31, 32'd0, 1'b0, 1'b0);
      run_home(8'd32, 32'd0, 1'b0, 1'b0);
      run_home(8'd36, 32'd0, 1'b0, 1'b0);
      run_home(8'd35, 32'd1000, 1'b0, 1'b1);
      run_home(8'd34, 32'd1024, 1'b1, 1'b1);
      run_home(8'd33, 32'd960, 1'b0, 1'b1);
      run_home(8'd1, 32'd256, 1'b0, 1'b1);
      run_home(8'd2, 32'd1792, 1'b1, 1'b1);
      run_home(8'd17, 32'd201, 1'b0, 1'b1);
      // hard stop while seeking the index ends in a fault
      od_check("method", 1'b1, IDX_HOMING_METHOD, 8'h00, {24'h0, METHOD_INDEX_POS}, 1'b0);
      homing_start = 1'b1;
      @(posedge ref_clk);
      #1;
      homing_start = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      hard_stop = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      hard_stop = 1'b0;
      chk("hard stop error", 32'h1, {31'h0, homing_error});
      chk("hard stop done", 32'h0, {31'h0, homing_done});
      od_check("limit wr", 1'b1, IDX_EFFORT_LIMIT, 8'h00, 32'd100, 1'b0);
      loop_effort = -32'sd300;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("effort clamp", -32'sd100, control_effort);
      loop_effort = 32'd50;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("effort pass", 32'd50, control_effort);
      summarize();
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      err_total++;
      summarize();
   end
endmodule : drive_homing_sequencer_tb_top
`default_nettype wire
